// ---- design/lad_drive_if.sv ----
// next-cycle drive request for the shared nibble lines
`timescale 1ns/1ns
interface lad_drive_if;
	logic       en;
	logic [3:0] nib;

	modport src (output en, output nib);
	modport dst (input en, input nib);
endinterface : lad_drive_if

// ---- design/lad_driver.sv ----
// output flops for the shared nibble lines
`timescale 1ns/1ns
module lad_driver (
	input  wire logic core_clk,
	input  wire logic rst_b,
	lad_drive_if.dst  drv,
	output logic [3:0] lad_out,
	output logic       lad_oe
);
	import locality_cycle_pkg::*;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			lad_out <= TAR_NIBBLE;
			lad_oe  <= 1'b0;
		end else begin
			lad_out <= drv.nib;
			lad_oe  <= drv.en;
		end
	end

endmodule : lad_driver

// ---- design/locality_cycle_decoder.sv ----
// target decoder for locality write and locality read bus cycles
//
// Operation
// - A cycle opens only when the frame strobe is low and the lines carry start code 0101.
// - A locality write carries cycle type 0010 right after the start code.
// - A locality read carries cycle type 0000 right after the start code.
// - Four address nibbles follow the cycle type, most significant first.
// - A write sends data low then high nibble, host turnaround, device ready sync, turnaround.
// - A read gets host turnaround, device sync, data low then high nibble, turnaround.
// - Cycles opened with the ordinary start code are never claimed.
// - Every access taken here is flagged as a locality access from a trusted source.
`timescale 1ns/1ns
module locality_cycle_decoder (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic        lframe_b,
	input  wire logic [3:0]  lad_in,
	output logic      [3:0]  lad_out,
	output logic             lad_oe,
	output logic             acc_valid,
	output logic      [15:0] acc_addr,
	output logic             acc_write,
	output logic      [7:0]  acc_wdata,
	output logic             acc_locality,
	input  wire logic [7:0]  rd_data,
	input  wire logic        rd_valid
);
	import locality_cycle_pkg::*;

	cycle_state_type state_r;
	logic [1:0]      cnt_r;
	logic            dir_wr_r;
	logic [15:0]     addr_r;
	logic [3:0]      wlow_r;
	logic [7:0]      rd_byte_r;
	logic            rd_have_r;
	logic            sync_ok_r;
	logic            ready;
	lad_drive_if     drv ();

	assign ready = dir_wr_r | rd_have_r;

	////////////////////////////////////////////////////////////////////////////
	// cycle sequencer
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r   <= S_IDLE;
			cnt_r     <= CNT_RESET;
			sync_ok_r <= 1'b0;
		end else if (!lframe_b) begin
			// last start nibble under the strobe wins; any other code drops us
			state_r   <= (lad_in == START_LOCALITY) ? S_TYPE : S_IDLE;
			cnt_r     <= CNT_RESET;
			sync_ok_r <= 1'b0;
		end else begin
			case (state_r)
				S_IDLE: begin
					cnt_r <= CNT_RESET;
				end
				S_TYPE: begin
					cnt_r <= CNT_RESET;
					if (lad_in == CT_IO_WRITE || lad_in == CT_IO_READ)
						state_r <= S_ADDR;
					else
						state_r <= S_IDLE;
				end
				S_ADDR: begin
					if (cnt_r == ADDR_LAST) begin
						cnt_r   <= CNT_RESET;
						state_r <= dir_wr_r ? S_WDAT : S_HTAR;
					end else
						cnt_r <= cnt_r + 2'h1;
				end
				S_WDAT: begin
					if (cnt_r == PAIR_LAST) begin
						cnt_r   <= CNT_RESET;
						state_r <= S_HTAR;
					end else
						cnt_r <= cnt_r + 2'h1;
				end
				S_HTAR: begin
					if (cnt_r == PAIR_LAST) begin
						cnt_r     <= CNT_RESET;
						state_r   <= S_SYNC;
						sync_ok_r <= ready;
					end else
						cnt_r <= cnt_r + 2'h1;
				end
				S_SYNC: begin
					cnt_r <= CNT_RESET;
					if (sync_ok_r)
						state_r <= dir_wr_r ? S_DTAR : S_RDAT;
					else
						sync_ok_r <= ready;
				end
				S_RDAT: begin
					if (cnt_r == PAIR_LAST) begin
						cnt_r   <= CNT_RESET;
						state_r <= S_DTAR;
					end else
						cnt_r <= cnt_r + 2'h1;
				end
				S_DTAR: begin
					if (cnt_r == PAIR_LAST) begin
						cnt_r   <= CNT_RESET;
						state_r <= S_IDLE;
					end else
						cnt_r <= cnt_r + 2'h1;
				end
				default: begin
					cnt_r   <= CNT_RESET;
					state_r <= S_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// field capture
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			dir_wr_r <= 1'b0;
			addr_r   <= ADDR_RESET;
			wlow_r   <= BYTE_RESET[3:0];
		end else if (lframe_b) begin
			if (state_r == S_TYPE)
				dir_wr_r <= (lad_in == CT_IO_WRITE);
			if (state_r == S_ADDR)
				addr_r <= {addr_r[11:0], lad_in};
			if (state_r == S_WDAT && cnt_r == CNT_RESET)
				wlow_r <= lad_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// access hand-off to register logic
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			acc_valid    <= 1'b0;
			acc_addr     <= ADDR_RESET;
			acc_write    <= 1'b0;
			acc_wdata    <= BYTE_RESET;
			acc_locality <= 1'b0;
		end else begin
			acc_valid <= 1'b0;
			if (lframe_b && state_r == S_ADDR && cnt_r == ADDR_LAST && !dir_wr_r) begin
				acc_valid    <= 1'b1;
				acc_addr     <= {addr_r[11:0], lad_in};
				acc_write    <= 1'b0;
				acc_locality <= 1'b1;
			end else if (lframe_b && state_r == S_WDAT && cnt_r == PAIR_LAST) begin
				acc_valid    <= 1'b1;
				acc_addr     <= addr_r;
				acc_write    <= 1'b1;
				acc_wdata    <= {lad_in, wlow_r};
				acc_locality <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read answer holding
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_byte_r <= BYTE_RESET;
			rd_have_r <= 1'b0;
		end else if (state_r == S_TYPE) begin
			rd_have_r <= 1'b0;
		end else if (rd_valid && !dir_wr_r && !rd_have_r) begin
			rd_byte_r <= rd_data;
			rd_have_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// what the lines carry on the next cycle
	always_comb begin
		drv.en  = 1'b0;
		drv.nib = TAR_NIBBLE;
		if (lframe_b) begin
			case (state_r)
				S_HTAR: begin
					if (cnt_r == PAIR_LAST) begin
						drv.en  = 1'b1;
						drv.nib = ready ? SYNC_READY : SYNC_LONG_WAIT;
					end
				end
				S_SYNC: begin
					drv.en = 1'b1;
					if (!sync_ok_r)
						drv.nib = ready ? SYNC_READY : SYNC_LONG_WAIT;
					else if (dir_wr_r)
						drv.nib = TAR_NIBBLE;
					else
						drv.nib = rd_byte_r[3:0];
				end
				S_RDAT: begin
					drv.en  = 1'b1;
					drv.nib = (cnt_r == CNT_RESET) ? rd_byte_r[7:4] : TAR_NIBBLE;
				end
				default: begin
					drv.en  = 1'b0;
					drv.nib = TAR_NIBBLE;
				end
			endcase
		end
	end

	lad_driver u_lad_driver (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.drv      (drv.dst),
		.lad_out  (lad_out),
		.lad_oe   (lad_oe)
	);

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	a_start_code: assert property (
		(state_r == S_TYPE) |-> $past(!lframe_b && lad_in == START_LOCALITY))
		else $error("type phase entered without locality start");

	a_write_type: assert property (
		(state_r == S_ADDR && $past(state_r) == S_TYPE && dir_wr_r)
		|-> $past(lad_in) == CT_IO_WRITE)
		else $error("write decoded from wrong cycle type");

	a_read_type: assert property (
		(state_r == S_ADDR && $past(state_r) == S_TYPE && !dir_wr_r)
		|-> $past(lad_in) == CT_IO_READ)
		else $error("read decoded from wrong cycle type");

	a_read_address: assert property (
		(acc_valid && !acc_write) |-> acc_addr ==
		{$past(lad_in, 4), $past(lad_in, 3), $past(lad_in, 2), $past(lad_in, 1)})
		else $error("read address not built from four nibbles");

	a_write_data: assert property (
		(acc_valid && acc_write) |-> acc_wdata == {$past(lad_in, 1), $past(lad_in, 2)})
		else $error("write byte not low nibble first");

	a_write_sync: assert property (
		(state_r == S_SYNC && dir_wr_r && lframe_b)
		|-> (lad_oe && lad_out == SYNC_READY) ##1 (lad_oe && lad_out == TAR_NIBBLE))
		else $error("write sync or turnaround wrong");

	a_read_data: assert property (
		(state_r == S_RDAT && cnt_r == CNT_RESET && lframe_b)
		|-> (lad_oe && lad_out == rd_byte_r[3:0]) ##1 (lad_oe && lad_out == rd_byte_r[7:4]))
		else $error("read data not low then high nibble");

	a_long_wait: assert property (
		(state_r == S_SYNC && !sync_ok_r) |-> lad_oe && lad_out == SYNC_LONG_WAIT)
		else $error("waiting sync not long wait");

	a_plain_ignored: assert property (
		(!lframe_b && lad_in == START_PLAIN) |=> state_r == S_IDLE && !lad_oe)
		else $error("ordinary start code claimed");

	a_locality_flag: assert property (
		acc_valid |-> acc_locality && $past(state_r == S_ADDR || state_r == S_WDAT))
		else $error("access without locality flag");

	c_write_done: cover property (state_r == S_DTAR && dir_wr_r ##1 state_r == S_DTAR);
	c_read_done: cover property (state_r == S_RDAT ##2 state_r == S_DTAR);
	c_long_wait: cover property (state_r == S_SYNC && !sync_ok_r ##1 sync_ok_r);
	c_abort: cover property (state_r == S_ADDR ##1 !lframe_b);

endmodule : locality_cycle_decoder

// ---- design/locality_cycle_pkg.sv ----
// constants and state type for the locality cycle decoder
package locality_cycle_pkg;

	localparam logic [3:0] START_LOCALITY = 4'h5;
	localparam logic [3:0] START_PLAIN    = 4'h0;
	localparam logic [3:0] CT_IO_WRITE    = 4'h2;
	localparam logic [3:0] CT_IO_READ     = 4'h0;
	localparam logic [3:0] SYNC_READY     = 4'h0;
	localparam logic [3:0] SYNC_LONG_WAIT = 4'h6;
	localparam logic [3:0] TAR_NIBBLE     = 4'hF;
	localparam logic [1:0] ADDR_LAST      = 2'h3;
	localparam logic [1:0] PAIR_LAST      = 2'h1;
	localparam logic [1:0] CNT_RESET      = 2'h0;
	localparam logic [15:0] ADDR_RESET    = 16'h0000;
	localparam logic [7:0] BYTE_RESET     = 8'h00;

	typedef enum logic [8:0] {
		S_IDLE = 9'h001,
		S_TYPE = 9'h002,
		S_ADDR = 9'h004,
		S_WDAT = 9'h008,
		S_HTAR = 9'h010,
		S_SYNC = 9'h020,
		S_RDAT = 9'h040,
		S_DTAR = 9'h080,
		S_SPARE = 9'h100
	} cycle_state_type;

endpackage : locality_cycle_pkg

// ---- testbench/lpc_host_model.sv ----
// host chipset model issuing locality cycles on the nibble lines
`timescale 1ns/1ns
module lpc_host_model (
	input  wire logic       core_clk,
	input  wire logic [3:0] lad_out,
	input  wire logic       lad_oe,
	output logic            lframe_b,
	output logic      [3:0] lad_wire
);
	logic       host_en;
	logic [3:0] host_nib;
	int         sync_miss = 0;

	// released lines float to the pull-up level
	assign lad_wire = host_en ? host_nib : (lad_oe ? lad_out : 4'hF);

	initial begin
		lframe_b = 1'b1;
		host_en  = 1'b0;
		host_nib = 4'hF;
	end

	task automatic put(input logic fr_b, input logic [3:0] nib);
		@(posedge core_clk);
		lframe_b <= fr_b;
		host_en  <= 1'b1;
		host_nib <= nib;
	endtask : put

	task automatic header(input logic [3:0] st, input logic [3:0] ty, input logic [15:0] a);
		put(1'b0, st);
		put(1'b1, ty);
		for (int i = 3; i >= 0; i--) begin
			put(1'b1, a[i*4 +: 4]);
		end
	endtask : header

	// host turnaround, then wait for the ready sync
	task automatic turn_sync();
		logic seen;
		seen = 1'b0;
		put(1'b1, 4'hF);
		@(posedge core_clk);
		host_en <= 1'b0;
		for (int n = 0; n < 64 && !seen; n++) begin
			@(posedge core_clk);
			seen = (lad_oe === 1'b1 && lad_out === 4'h0);
		end
		if (!seen) sync_miss++;
	endtask : turn_sync

	task automatic lw(input logic [15:0] a, input logic [7:0] d);
		header(4'h5, 4'h2, a);
		put(1'b1, d[3:0]);
		put(1'b1, d[7:4]);
		turn_sync();
		@(posedge core_clk);
	endtask : lw

	task automatic lr(input logic [15:0] a, output logic [7:0] d);
		header(4'h5, 4'h0, a);
		turn_sync();
		@(posedge core_clk);
		d[3:0] = lad_wire;
		@(posedge core_clk);
		d[7:4] = lad_wire;
		@(posedge core_clk);
	endtask : lr

	task automatic lw_word(input logic [15:0] a, input logic [31:0] v);
		for (int i = 0; i < 4; i++) begin
			lw(a + 16'(i), v[i*8 +: 8]);
		end
	endtask : lw_word

	task automatic lr_word(input logic [15:0] a, output logic [31:0] v);
		for (int i = 0; i < 4; i++) begin
			lr(a + 16'(i), v[i*8 +: 8]);
		end
	endtask : lr_word

	// cycle the device must leave alone
	task automatic ignored(input logic [3:0] st, input logic [3:0] ty, input logic [15:0] a,
		output logic claimed);
		header(st, ty, a);
		put(1'b1, 4'hF);
		@(posedge core_clk);
		host_en <= 1'b0;
		claimed = 1'b0;
		repeat (10) begin
			@(posedge core_clk);
			if (lad_oe !== 1'b0) claimed = 1'b1;
		end
	endtask : ignored

	// locality write cut short by a new strobe in the address phase
	task automatic cut(input logic [15:0] a, output logic claimed);
		put(1'b0, 4'h5);
		put(1'b1, 4'h2);
		put(1'b1, a[15:12]);
		ignored(4'h0, 4'h2, a, claimed);
	endtask : cut
endmodule : lpc_host_model

// ---- testbench/lpc_locality_cycle_decoder_tb.sv ----
// self-checking bench for the locality cycle decoder
`timescale 1ns/1ns
module lpc_locality_cycle_decoder_tb;
	typedef struct packed {
		logic [15:0] addr;
		logic        wr;
		logic [7:0]  wdata;
	} note_type;

	logic        core_clk = 1'b0;
	logic        rst_b;
	logic        lframe_b;
	logic [3:0]  lad_wire;
	logic [3:0]  lad_out;
	logic        lad_oe;
	logic        acc_valid;
	logic [15:0] acc_addr;
	logic        acc_write;
	logic [7:0]  acc_wdata;
	logic        acc_locality;
	logic [7:0]  rd_data;
	logic        rd_valid;
	logic [2:0]  rd_delay;
	logic [2:0]  rd_cnt;
	logic        rd_pend;
	logic        rd_early;
	logic [7:0]  rd_next;
	logic [7:0]  salt;
	logic [15:0] a;
	logic [31:0] w;
	logic [7:0]  got;
	logic        claimed;
	integer      seed;
	int          fail_count = 0;
	int          n_checks = 0;
	note_type    notes[$];

	always #5 core_clk = ~core_clk;

	lpc_host_model i_host (.core_clk(core_clk), .lad_out(lad_out), .lad_oe(lad_oe),
		.lframe_b(lframe_b), .lad_wire(lad_wire));

	locality_cycle_decoder i_dut (.core_clk(core_clk), .rst_b(rst_b), .lframe_b(lframe_b),
		.lad_in(lad_wire), .lad_out(lad_out), .lad_oe(lad_oe), .acc_valid(acc_valid),
		.acc_addr(acc_addr), .acc_write(acc_write), .acc_wdata(acc_wdata),
		.acc_locality(acc_locality), .rd_data(rd_data), .rd_valid(rd_valid));

	////////////////////////////////////////////////////////////////////////////////////////
	task automatic mismatch(input string msg);
		fail_count++;
		$display("wrong value at %0t: %s", $time, msg);
	endtask : mismatch

	task automatic cmp_acc(input note_type e);
		n_checks++;
		if (acc_addr !== e.addr || acc_write !== e.wr || acc_locality !== 1'b1 ||
			(e.wr && acc_wdata !== e.wdata)) mismatch("access fields");
	endtask : cmp_acc

	task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) mismatch("byte");
	endtask : cmp_byte

	task automatic test_done;
		if (fail_count == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : test_done

	////////////////////////////////////////////////////////////////////////////////////////
	always @(posedge core_clk) begin
		if (acc_valid === 1'b1) begin
			if (notes.size() == 0) mismatch("unexpected access");
			else cmp_acc(notes.pop_front());
		end
	end

	// register side answers reads after a chosen delay, or holds its answer up in early mode
	always @(posedge core_clk) begin
		if (rd_early) begin
			rd_valid <= 1'b1;
			rd_data  <= rd_next;
		end else if (acc_valid === 1'b1 && acc_write === 1'b0) begin
			rd_valid <= (rd_delay == 3'h0);
			rd_pend  <= (rd_delay != 3'h0);
			rd_cnt   <= rd_delay - 3'h1;
			rd_data  <= acc_addr[7:0] ^ salt;
		end else if (rd_pend && rd_cnt == 3'h0) begin
			rd_valid <= 1'b1;
			rd_pend  <= 1'b0;
		end else begin
			rd_valid <= 1'b0;
			if (rd_pend) rd_cnt <= rd_cnt - 3'h1;
		end
	end

	task automatic tb_write(input logic [15:0] ad, input logic [7:0] d);
		notes.push_back(note_type'{ad, 1'b1, d});
		i_host.lw(ad, d);
	endtask : tb_write

	task automatic tb_read(input logic [15:0] ad);
		notes.push_back(note_type'{ad, 1'b0, 8'h00});
		rd_next <= ad[7:0] ^ salt;
		i_host.lr(ad, got);
		cmp_byte(got, ad[7:0] ^ salt);
	endtask : tb_read

	initial begin
		#500000;
		mismatch("timeout");
		test_done;
	end

	initial begin
		seed = 32'hC2CC;
		rst_b = 1'b0;
		rd_data = 8'h00;
		rd_valid = 1'b0;
		rd_pend = 1'b0;
		rd_cnt = 3'h0;
		rd_delay = 3'h0;
		rd_early = 1'b0;
		rd_next = 8'h00;
		salt = $random(seed);
		repeat (20) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		cmp_byte({6'h00, lad_oe, acc_locality}, 8'h00);
		for (int k = 0; k < 8; k++) begin
			a = $random(seed);
			w = $random(seed);
			rd_delay <= k[2:0];
			rd_early <= (k == 3);
			tb_write(a, w[7:0]);
			tb_read(a + 16'h0001);
		end
		tb_write(16'hFFFF, 8'hA5);
		tb_read(16'h0000);
		i_host.ignored(4'h0, 4'h2, a, claimed);
		cmp_byte({7'h00, claimed}, 8'h00);
		i_host.ignored(4'h0, 4'h0, a, claimed);
		cmp_byte({7'h00, claimed}, 8'h00);
		i_host.ignored(4'h5, 4'h7, a, claimed);
		cmp_byte({7'h00, claimed}, 8'h00);
		i_host.cut(a, claimed);
		cmp_byte({7'h00, claimed}, 8'h00);
		for (int i = 0; i < 4; i++) notes.push_back(note_type'{a + 16'(i), 1'b1, w[i*8 +: 8]});
		i_host.lw_word(a, w);
		for (int i = 0; i < 4; i++) notes.push_back(note_type'{a + 16'(i), 1'b0, 8'h00});
		i_host.lr_word(a, w);
		for (int i = 0; i < 4; i++) cmp_byte(w[i*8 +: 8], 8'(a + 16'(i)) ^ salt);
		repeat (4) @(posedge core_clk);
		if (notes.size() != 0) mismatch("missing access");
		cmp_byte(8'(i_host.sync_miss), 8'h00);
		test_done;
	end
endmodule : lpc_locality_cycle_decoder_tb
